// >>> src/sonet_serdes_regs.vh
// Offsets, field positions, reset values and timing counts of the SONET parallel control block
`ifndef SONET_SERDES_REGS_VH
`define SONET_SERDES_REGS_VH

`define CORE_CLK_PERIOD_NS  50
`define LOS_TIME_NS         2300
`define LOS_CYCLES          ((`LOS_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`define NIBBLE_BITS         4
`define FRAME_PULSE_CYCLES  16
`define FRAME_PULSE_DELAY   8
`define PARITY_LOW_CYCLES   2
`define LOCK_TRANSITIONS    15
`define RATE_WINDOW_CYCLES  255
`define FRAME_PATTERN       16'hf628

`define MODE_TX_ONLY        2'h0
`define MODE_RX_ONLY        2'h1
`define MODE_TRANSCEIVER    2'h2
`define MODE_REPEATER       2'h3

`define REG_STATUS          4'h0
`define REG_MASK            4'h1
`define REG_LIVE            4'h2
`define REG_RESET_VALUE     8'h00

`define EV_LOS_RISE         0
`define EV_LOCK_LOST        1
`define EV_PARITY_ERR       2
`define EV_FRAME_FOUND      3

`endif

// >>> src/sonet_serdes_parallel_ctrl.v
// Parallel side, framing, rate detect, lock and loss-of-signal logic of a SONET serdes
//
// Operation
// - Frame found: boundary pulse four word clocks
// - Receive nibble valid at falling edge, bit0 first
// - Transmit nibble captured on rising edge, bit0 first
// - Autodetect enabled: report line rate code
// - Mode pins select tx, rx, transceiver, repeater
// - Standby low disables device, high operates
// - Framing enable controls byte alignment logic
// - Lock-to-reference low: word clock from reference
// - Local loopback routes transmit serial into receive
// - Lock indicator high when locked within tolerance
// - Loop timing times transmit from recovered clock
// - No transitions 2.3 us: signal lost, zeros
// - Valid signal received clears signal lost
// - Transmit parity even; error pulses flag low for two clocks
// - Reset pin low holds transmit hold and lock
// - Signal detect XOR polarity; loss forces zeros
// - Transmit clock source locked to reference
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "sonet_serdes_regs.vh"

module sonet_serdes_parallel_ctrl #(
	parameter LOS_CYCLES = `LOS_CYCLES
) (
	input  wire       i_core_clk,
	input  wire       i_rst,
	input  wire       i_reset_n,
	input  wire       i_serial_rx,
	input  wire       i_signal_detect_in,
	input  wire       i_signal_detect_polarity,
	input  wire       i_standby_enable,
	input  wire       i_frame_enable,
	input  wire       i_rate_autodetect_enable,
	input  wire       i_operating_mode_select_lsb,
	input  wire       i_operating_mode_select_msb,
	input  wire       i_lock_to_reference_n,
	input  wire       i_local_loopback_enable,
	input  wire       i_loop_timing_enable,
	input  wire       i_transmit_word_clock,
	input  wire [3:0] i_transmit_nibble,
	input  wire       i_transmit_parity_bit,
	input  wire [3:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	output reg        o_serial_tx,
	output reg        o_recovered_word_clock,
	output reg  [3:0] o_receive_nibble,
	output reg        o_receive_parity_bit,
	output reg        o_frame_boundary_pulse,
	output reg        o_detected_rate_code_lsb,
	output reg        o_detected_rate_code_msb,
	output reg        o_lock_indicator,
	output reg        o_signal_lost,
	output reg        o_parity_good_flag,
	output reg        o_transmit_clock_source,
	output reg  [7:0] o_reg_rdata,
	output wire       o_irq
);

	// Every pin but the register port and i_rst passes two flops; the nibble travels with its clock so they stay aligned
	localparam PW = 18;
	localparam FP_LOAD = `FRAME_PULSE_CYCLES + `FRAME_PULSE_DELAY;
	localparam PAR_LOW = `PARITY_LOW_CYCLES;
	wire [PW-1:0] pins_w = {i_reset_n, i_transmit_parity_bit, i_transmit_nibble,
		i_transmit_word_clock, i_loop_timing_enable, i_local_loopback_enable,
		i_lock_to_reference_n, i_operating_mode_select_msb, i_operating_mode_select_lsb,
		i_rate_autodetect_enable, i_frame_enable, i_standby_enable,
		i_signal_detect_polarity, i_signal_detect_in, i_serial_rx};
	reg  [PW-1:0] meta_r;
	reg  [PW-1:0] sync_r;

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= {PW{1'b0}};
			sync_r <= {PW{1'b0}};
		end
		else
		begin
			meta_r <= pins_w;
			sync_r <= meta_r;
		end
	end

	wire       s_serial_rx  = sync_r[0];
	wire       s_signal_detect_in     = sync_r[1];
	wire       s_polarity   = sync_r[2];
	wire       s_standby    = sync_r[3];
	wire       s_frame_en   = sync_r[4];
	wire       s_autodetect = sync_r[5];
	wire [1:0] s_mode       = sync_r[7:6];
	wire       s_lckref_n   = sync_r[8];
	wire       s_local_loopback_enable      = sync_r[9];
	wire       s_loop_timing_enable   = sync_r[10];
	wire       s_txclk      = sync_r[11];
	wire [3:0] s_txnib      = sync_r[15:12];
	wire       s_transmit_parity_bit      = sync_r[16];
	wire       s_reset_n    = sync_r[17];

	wire active_w = s_standby;
	wire tx_on_w  = active_w & ((s_mode == `MODE_TX_ONLY) | (s_mode == `MODE_TRANSCEIVER));
	wire rx_on_w  = active_w & (s_mode != `MODE_TX_ONLY);
	wire rpt_w    = active_w & (s_mode == `MODE_REPEATER);

	reg  [1:0]  ref_ph_r;
	reg  [1:0]  rx_ph_r;
	reg         prev_bit_r;
	reg  [15:0] hist_r;
	reg  [2:0]  acc_r;
	reg  [3:0]  word_r;
	reg  [7:0]  los_cnt_r;
	reg  [4:0]  fp_cnt_r;
	reg  [3:0]  lock_cnt_r;
	reg  [7:0]  win_r;
	reg  [3:0]  run_r;
	reg  [3:0]  min_run_r;
	reg  [1:0]  rate_r;
	reg         txclk_d_r;
	reg  [3:0]  hold_r;
	reg  [3:0]  tx_sh_r;
	reg  [1:0]  perr_cnt_r;
	reg  [7:0]  status_r;
	reg  [7:0]  mask_r;

	wire rx_bit_w  = s_local_loopback_enable ? o_serial_tx : s_serial_rx;
	wire trans_w   = rx_bit_w ^ prev_bit_r;
	wire sd_loss_w = s_signal_detect_in ^ s_polarity;
	wire [15:0] hist_nxt = {hist_r[14:0], rx_bit_w};
	wire match_w   = (hist_nxt == `FRAME_PATTERN);
	wire align_w   = match_w & s_frame_en;
	wire los_now_w = sd_loss_w | (los_cnt_r >= LOS_CYCLES[7:0]);
	wire los_nxt   = los_now_w | (o_signal_lost & ~match_w);
	wire [1:0] ref_ph_nxt = ref_ph_r + 2'h1;
	wire [1:0] rx_ph_nxt  = align_w ? 2'h0 : rx_ph_r + 2'h1;
	wire use_ref_w = ~s_lckref_n | o_signal_lost;
	wire [1:0] sel_ph_w   = use_ref_w ? ref_ph_r : rx_ph_r;
	wire [1:0] sel_ph_nxt = use_ref_w ? ref_ph_nxt : rx_ph_nxt;
	wire [1:0] tx_ph_w    = s_loop_timing_enable ? rx_ph_r : ref_ph_r;
	wire [4:0] fp_cnt_nxt = (align_w & ~use_ref_w) ? FP_LOAD[4:0]
		: ((fp_cnt_r != 5'h0) ? fp_cnt_r - 5'h1 : 5'h0);

	// Receive side: assemble, align, present on the selected word clock
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ref_ph_r               <= 2'h0;
			rx_ph_r                <= 2'h0;
			prev_bit_r             <= 1'b0;
			hist_r                 <= 16'h0000;
			acc_r                  <= 3'h0;
			word_r                 <= 4'h0;
			los_cnt_r              <= 8'h00;
			fp_cnt_r               <= 5'h00;
			o_recovered_word_clock <= 1'b0;
			o_receive_nibble       <= 4'h0;
			o_receive_parity_bit   <= 1'b0;
			o_frame_boundary_pulse <= 1'b0;
			o_signal_lost          <= 1'b1;
			o_transmit_clock_source <= 1'b0;
		end
		else
		begin
			ref_ph_r   <= ref_ph_nxt;
			rx_ph_r    <= rx_ph_nxt;
			prev_bit_r <= rx_bit_w;
			hist_r     <= hist_nxt;
			fp_cnt_r   <= fp_cnt_nxt;
			if (trans_w)
				los_cnt_r <= 8'h00;
			else if (los_cnt_r != 8'hff)
				los_cnt_r <= los_cnt_r + 8'h01;
			o_signal_lost <= los_nxt;
			if (rx_ph_r == 2'h3)
				word_r <= {rx_bit_w, acc_r};
			else
				acc_r[rx_ph_r] <= rx_bit_w;
			// Nibble changes on the rising clock edge, so it is settled at the falling one
			o_recovered_word_clock <= active_w & ~sel_ph_nxt[1];
			o_transmit_clock_source <= active_w & ~ref_ph_nxt[1];
			if (sel_ph_w == 2'h3)
			begin
				// Loss of signal sends zeros, timed from the reference
				o_receive_nibble     <= (rx_on_w & ~los_nxt) ? word_r : 4'h0;
				o_receive_parity_bit <= (rx_on_w & ~los_nxt) ? ^word_r : 1'b0;
			end
			o_frame_boundary_pulse <= rx_on_w & (fp_cnt_nxt != 5'h0)
				& (fp_cnt_nxt <= `FRAME_PULSE_CYCLES);
		end
	end

	// Rate detect from the shortest run length seen in a window
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			win_r     <= 8'h00;
			run_r     <= 4'h1;
			min_run_r <= 4'hf;
			rate_r    <= 2'h0;
		end
		else
		begin
			win_r <= win_r + 8'h01;
			if (trans_w)
				run_r <= 4'h1;
			else if (run_r != 4'hf)
				run_r <= run_r + 4'h1;
			if (win_r == `RATE_WINDOW_CYCLES)
			begin
				min_run_r <= 4'hf;
				if (min_run_r <= 4'h1)
					rate_r <= 2'h0;
				else if (min_run_r <= 4'h2)
					rate_r <= 2'h1;
				else if (min_run_r <= 4'h4)
					rate_r <= 2'h2;
				else
					rate_r <= 2'h3;
			end
			else if (trans_w && (run_r < min_run_r))
				min_run_r <= run_r;
		end
	end

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_detected_rate_code_lsb <= 1'b0;
			o_detected_rate_code_msb <= 1'b0;
		end
		else
		begin
			o_detected_rate_code_lsb <= active_w & s_autodetect & rate_r[0];
			o_detected_rate_code_msb <= active_w & s_autodetect & rate_r[1];
		end
	end

	// Tolerance check is reduced to a run of good transitions without loss
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lock_cnt_r       <= 4'h0;
			o_lock_indicator <= 1'b0;
		end
		else
		begin
			if (~s_reset_n | ~active_w | los_nxt)
				lock_cnt_r <= 4'h0;
			else if (trans_w && (lock_cnt_r != `LOCK_TRANSITIONS))
				lock_cnt_r <= lock_cnt_r + 4'h1;
			o_lock_indicator <= s_reset_n & active_w & ~los_nxt
				& (lock_cnt_r == `LOCK_TRANSITIONS);
		end
	end

	// Transmit side: capture on framer clock rise, check parity, serialize bit0 first
	wire txclk_rise_w = s_txclk & ~txclk_d_r;
	// Even parity: an odd count of ones over nibble and parity is the error
	wire par_err_w    = txclk_rise_w & tx_on_w & (^{s_txnib, s_transmit_parity_bit});

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			txclk_d_r          <= 1'b0;
			hold_r             <= 4'h0;
			tx_sh_r            <= 4'h0;
			perr_cnt_r         <= 2'h0;
			o_parity_good_flag <= 1'b1;
			o_serial_tx        <= 1'b0;
		end
		else
		begin
			txclk_d_r <= s_txclk;
			if (~s_reset_n)
				hold_r <= 4'h0;
			else if (txclk_rise_w)
				hold_r <= s_txnib;
			if (par_err_w)
				perr_cnt_r <= PAR_LOW[1:0];
			else if (perr_cnt_r != 2'h0)
				perr_cnt_r <= perr_cnt_r - 2'h1;
			o_parity_good_flag <= ~(par_err_w | (perr_cnt_r > 2'h1));
			if (tx_ph_w == 2'h3)
				tx_sh_r <= hold_r;
			else
				tx_sh_r <= {1'b0, tx_sh_r[3:1]};
			if (rpt_w)
				o_serial_tx <= los_nxt ? 1'b0 : rx_bit_w;
			else
				o_serial_tx <= tx_on_w & ~los_nxt & tx_sh_r[0];
		end
	end

	// Status bits are sticky, cleared by writing one; a new event beats the clear
	wire [7:0] events_w;
	assign events_w[`EV_LOS_RISE]   = los_nxt & ~o_signal_lost;
	assign events_w[`EV_LOCK_LOST]  = o_lock_indicator & ~s_reset_n;
	assign events_w[`EV_PARITY_ERR] = par_err_w;
	assign events_w[`EV_FRAME_FOUND] = align_w;
	assign events_w[7:4]            = 4'h0;
	wire lock_drop_w = o_lock_indicator & (los_nxt | ~active_w);

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			status_r    <= `REG_RESET_VALUE;
			mask_r      <= `REG_RESET_VALUE;
			o_reg_rdata <= 8'h00;
		end
		else
		begin
			status_r <= (status_r & ~((i_reg_wr && (i_reg_addr == `REG_STATUS)) ? i_reg_wdata
				: 8'h00)) | events_w | {6'h00, lock_drop_w, 1'b0};
			if (i_reg_wr && (i_reg_addr == `REG_MASK))
				mask_r <= i_reg_wdata;
			if (i_reg_rd)
			begin
				case (i_reg_addr)
					`REG_STATUS: o_reg_rdata <= status_r;
					`REG_MASK:   o_reg_rdata <= mask_r;
					`REG_LIVE:   o_reg_rdata <= {s_mode, rate_r, o_parity_good_flag,
						o_frame_boundary_pulse, o_lock_indicator, o_signal_lost};
					default:     o_reg_rdata <= 8'h00;
				endcase
			end
			else
				o_reg_rdata <= 8'h00;
		end
	end

	assign o_irq = |(status_r & mask_r);

endmodule // sonet_serdes_parallel_ctrl

// >>> verification/serdes_ctrl_checker.sv
// Port assertions for the SONET parallel control block
`timescale 1ns/1ns
module serdes_ctrl_checker (
	input wire       i_core_clk,
	input wire       i_rst,
	input wire       i_reset_n,
	input wire       i_standby_enable,
	input wire       i_reg_rd,
	input wire       o_frame_boundary_pulse,
	input wire [3:0] o_receive_nibble,
	input wire       o_receive_parity_bit,
	input wire       o_lock_indicator,
	input wire       o_signal_lost,
	input wire       o_parity_good_flag,
	input wire       o_transmit_clock_source,
	input wire [7:0] o_reg_rdata
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	a_frame_pulse_len: assert property ($rose(o_frame_boundary_pulse) |->
		o_frame_boundary_pulse[*8] ##1 o_frame_boundary_pulse[*8] ##1 !o_frame_boundary_pulse)
		else $error("frame pulse length");
	a_parity_low_two: assert property ($fell(o_parity_good_flag) |-> ##1
		!o_parity_good_flag ##1 o_parity_good_flag) else $error("parity flag width");
	a_rdata_slot_only: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_rx_parity_even: assert property (o_receive_parity_bit == ^o_receive_nibble)
		else $error("receive parity odd");
	// Standby gating may cut a phase short, so it suspends the check
	a_txclk_shape: assert property (disable iff (i_rst || !i_standby_enable)
		$fell(o_transmit_clock_source) |-> !o_transmit_clock_source[*2] ##1
		o_transmit_clock_source[*2] ##1 !o_transmit_clock_source) else $error("tx clock shape");
	a_standby_quiet: assert property (!i_standby_enable[*4] |-> !o_lock_indicator &&
		!o_frame_boundary_pulse && o_parity_good_flag) else $error("standby not quiet");
	a_lock_held_reset: assert property (!i_reset_n[*4] |-> !o_lock_indicator)
		else $error("lock during reset");
	a_lost_rx_zero: assert property (o_signal_lost[*6] |-> o_receive_nibble == 4'h0)
		else $error("nibble while lost");
	c_frame: cover property ($rose(o_frame_boundary_pulse));
	c_parity: cover property ($fell(o_parity_good_flag));
	c_lost: cover property ($rose(o_signal_lost));
endmodule // serdes_ctrl_checker

bind sonet_serdes_parallel_ctrl serdes_ctrl_checker serdes_ctrl_checker_i (.*);

// >>> verification/framer_model.sv
// Framer model driving the transmit nibble bus
`timescale 1ns/1ns
module framer_model (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_bad_par,
	output reg        o_twc,
	output reg  [3:0] o_nib,
	output reg        o_par
);
	reg [2:0] cnt_r;

	// Nibble moves in the low phase so it is steady at the capturing rise
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			{cnt_r, o_twc, o_nib, o_par} <= 9'h000;
		else
		begin
			cnt_r <= cnt_r + 3'h1;
			o_twc <= cnt_r[2];
			if (cnt_r == 3'h1)
			begin
				o_nib <= o_nib + 4'h1;
				o_par <= ^(o_nib + 4'h1) ^ i_bad_par;
			end
		end
	end
endmodule // framer_model

// >>> verification/sonet_serdes_parallel_ctrl_tb.sv
// Self-checking bench for the SONET parallel control block
`timescale 1ns/1ns
`include "sonet_serdes_regs.vh"
module sonet_serdes_parallel_ctrl_tb;
	reg        clk = 1'b0, rst = 1'b1, rx = 1'b1, pol = 1'b0, stby = 1'b1, pin_rst_n = 1'b1;
	reg        autod = 1'b1, local_loopback_enable = 1'b0, bad = 1'b0, wr = 1'b0, rd = 1'b0;
	reg        fen = 1'b1, lckref_n = 1'b1, hit = 1'b0;
	reg  [3:0] pnib = 4'h0;
	reg  [1:0] mode = `MODE_TRANSCEIVER;
	reg  [3:0] addr = 4'h0;
	reg  [7:0] wdata = 8'h00, rv;
	wire       twc, tpar, lost, pg, irq, fp, lock, r0, r1;
	wire       rwc, tcs, stx;
	wire [3:0] tnib, rnib;
	wire [7:0] rdata;
	integer    failures = 0, checked = 0, fpn = 0, i, txn = 0, n;

	always #25 clk = ~clk;
	always @(posedge clk) if (fp) fpn <= fpn + 1;
	always @(posedge clk) if (stx) txn <= txn + 1;
	always @(posedge clk) pnib <= rnib;
	// After alignment on A2 the first nibbles are 4 then 1 when bit0 is the earliest bit
	always @(posedge clk) if (pnib == 4'h4 && rnib == 4'h1) hit <= 1'b1;
	framer_model framer_model_i (.i_clk(clk), .i_rst(rst), .i_bad_par(bad), .o_twc(twc),
		.o_nib(tnib), .o_par(tpar));
	sonet_serdes_parallel_ctrl #(.LOS_CYCLES(8)) sonet_serdes_parallel_ctrl_i (
		.i_core_clk(clk), .i_rst(rst), .i_reset_n(pin_rst_n), .i_serial_rx(rx),
		.i_signal_detect_in(1'b0), .i_signal_detect_polarity(pol), .i_standby_enable(stby),
		.i_frame_enable(fen), .i_rate_autodetect_enable(autod),
		.i_operating_mode_select_lsb(mode[0]), .i_operating_mode_select_msb(mode[1]),
		.i_lock_to_reference_n(lckref_n), .i_local_loopback_enable(local_loopback_enable),
		.i_loop_timing_enable(local_loopback_enable), .i_transmit_word_clock(twc), .i_transmit_nibble(tnib),
		.i_transmit_parity_bit(tpar), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_serial_tx(stx), .o_recovered_word_clock(rwc), .o_receive_nibble(rnib),
		.o_receive_parity_bit(), .o_frame_boundary_pulse(fp), .o_detected_rate_code_lsb(r0),
		.o_detected_rate_code_msb(r1), .o_lock_indicator(lock), .o_signal_lost(lost),
		.o_parity_good_flag(pg), .o_transmit_clock_source(tcs), .o_reg_rdata(rdata), .o_irq(irq));

	task tick(input integer n); repeat (n) @(posedge clk); endtask
	task check(input [7:0] seen, input [7:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task wr_reg(input [3:0] a, input [7:0] d);
	begin
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		tick(1);
		wr <= 1'b0;
		tick(1);
	end
	endtask
	task rd_reg(input [3:0] a, output [7:0] d);
	begin
		addr <= a;
		rd <= 1'b1;
		tick(1);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		tick(1);
	end
	endtask
	// Three A1, three A2, then padding; most significant bit first as on the line
	task frame;
		reg [95:0] pat;
		integer k;
	begin
		pat = {24'hf6f6f6, 24'h282828, 48'h555555555555};
		for (k = 95; k >= 0; k = k - 1)
		begin
			rx <= pat[k];
			tick(1);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// Run needs under 1500 cycles
	initial
	begin
		tick(20000);
		failures = failures + 1;
		finish_test;
	end

	initial
	begin
		tick(8);
		rst <= 1'b0;
		tick(4);
		check(8'(lost), 8'h01);
		rd_reg(`REG_MASK, rv);
		check(rv, `REG_RESET_VALUE);
		rd_reg(4'hf, rv);
		check(rv, 8'h00);
		for (i = 0; i < 4; i = i + 1)
		begin
			mode <= i[1:0];
			tick(4);
			rd_reg(`REG_LIVE, rv);
			check(8'(rv[7:6]), 8'(i));
		end
		mode <= `MODE_TRANSCEIVER;
		wr_reg(`REG_STATUS, 8'hff);
		wr_reg(`REG_MASK, 8'h0f);
		frame;
		frame;
		check(8'(lost), 8'h00);
		check(8'(lock), 8'h01);
		check(8'(fpn == 16 || fpn == 32), 8'h01);
		check(8'(hit), 8'h01);
		check(8'(txn != 0), 8'h01);
		rd_reg(`REG_STATUS, rv);
		check(8'(rv[3]), 8'h01);
		check(8'(rv[2]), 8'h00);
		bad <= 1'b1;
		for (i = 0; i < 40 && pg !== 1'b0; i = i + 1)
			tick(1);
		bad <= 1'b0;
		check(8'(pg), 8'h00);
		tick(12);
		rd_reg(`REG_STATUS, rv);
		check(8'(rv[2]), 8'h01);
		pin_rst_n <= 1'b0;
		tick(6);
		check(8'(lock), 8'h00);
		pin_rst_n <= 1'b1;
		wr_reg(`REG_STATUS, 8'hff);
		// Signal lost is set by now; a frame without alignment clears it
		fen <= 1'b0;
		frame;
		fen <= 1'b1;
		rx <= 1'b0;
		tick(5);
		check(8'(lost), 8'h00);
		tick(12);
		check(8'(lost), 8'h01);
		check(8'(irq), 8'h01);
		rd_reg(`REG_STATUS, rv);
		check(8'(rv[0]), 8'h01);
		check(8'(rv[3]), 8'h00);
		wr_reg(`REG_MASK, 8'h00);
		check(8'(irq), 8'h00);
		// No transitions for a whole window gives the slowest rate code
		tick(520);
		check(8'({r1, r0}), 8'h03);
		fork
			frame;
			begin
				tick(50);
				lckref_n <= 1'b0;
				tick(4);
				repeat (8)
				begin
					check(8'(rwc), 8'(tcs));
					tick(1);
				end
				lckref_n <= 1'b1;
			end
		join
		pol <= 1'b1;
		tick(6);
		check(8'(lost), 8'h01);
		n = txn;
		tick(8);
		check(8'(txn - n), 8'h00);
		pol <= 1'b0;
		autod <= 1'b0;
		stby <= 1'b0;
		tick(6);
		check(8'({r1, r0}), 8'h00);
		check(8'(pg), 8'h01);
		stby <= 1'b1;
		local_loopback_enable <= 1'b1;
		tick(4);
		// Pin stream is ignored in loopback, so the pattern cannot clear the loss
		frame;
		check(8'(lost), 8'h01);
		finish_test;
	end
endmodule // sonet_serdes_parallel_ctrl_tb
